//--- core/sis_consts.vh
// register map, field layout, reset values and legal address windows
`ifndef SIS_CONSTS_VH
`define SIS_CONSTS_VH
// byte offsets of the fixed registers
`define SIS_PEND0_OFS 12'h000
`define SIS_PEND1_OFS 12'h004
`define SIS_LEVEL_OFS 12'h008
// configuration words sit at 12'h040 + 4*index
`define SIS_CFG_PAGE 6'h01
`define SIS_CFG_NUM 14
`define SIS_CFG_GFX_PROT 4'h0
`define SIS_CFG_PER_PROT 4'h1
`define SIS_CFG_BOOT_PROT 4'h2
`define SIS_CFG_EXP_PROT 4'h3
`define SIS_CFG_VBLANK 4'h4
`define SIS_CFG_HBLANK 4'h5
`define SIS_CFG_PLIMIT 4'h6
`define SIS_CFG_OLIMIT 4'h7
`define SIS_CFG_YUV 4'h8
`define SIS_CFG_TMO 4'h9
`define SIS_CFG_EXP_SA0 4'hA
// reset values
`define SIS_CFG_RST 32'h0000_0000
`define SIS_TMO_RST 32'h0000_00FF
`define SIS_INHIB_LO 32'hFFFF_FFFF
`define SIS_INHIB_HI 32'h0000_0000
// fields
`define SIS_WIN_LO 15:0
`define SIS_WIN_HI 31:16
`define SIS_LINE_A 9:0
`define SIS_LINE_B 25:16
`define SIS_HMODE 13:12
`define SIS_MB_CNT 15:0
// hblank_line_select modes
`define SIS_HM_LINE 2'h0
`define SIS_HM_EVERY_N 2'h1
`define SIS_HM_ALL 2'h2
// dma kinds
`define SIS_K_GFX 2'h0
`define SIS_K_PER 2'h1
`define SIS_K_BOOT 2'h2
`define SIS_K_EXP 2'h3
// address windows
`define SIS_WAVE_LO 32'h0080_0000
`define SIS_WAVE_HI 32'h00FF_FFE0
`define SIS_TEX_LO 32'h0400_0000
`define SIS_TEX_HI 32'h05FF_FFE0
`define SIS_SYS_LO 32'h0C00_0000
`define SIS_SYS_HI 32'h0FFF_FFE0
`define SIS_EXT_LO 32'h1400_0000
`define SIS_EXT_HI 32'h17FF_FFE0
// pending flag positions
`define SIS_B_EXP_DONE 0
`define SIS_B_EXP_BAD 4
`define SIS_B_EXP_TMO 8
`define SIS_B_CPU_TMO 12
`define SIS_B_CH2_DONE 13
`define SIS_B_SORT_DONE 14
`define SIS_B_SORT_ERR 15
`define SIS_B_INHIB 16
`define SIS_B_RVIDEO 17
`define SIS_B_RHSR 18
`define SIS_B_RSHADE 19
`define SIS_B_VBS 20
`define SIS_B_VBE 21
`define SIS_B_HBS 22
`define SIS_B_CACHE 23
`define SIS_B_HAZARD 24
`define SIS_B_YUV 25
`define SIS_B_LISTS 26
`define SIS_B_PLIM 31
`define SIS_B_OLIM 32
`define SIS_B_ILLPAR 33
`define SIS_B_FIFO 34
`define SIS_B_SYS_BAD 35
`define SIS_B_SYS_OVR 38
// bus responses
`define SIS_RESP_OKAY 2'h0
`define SIS_RESP_SLVERR 2'h2
`endif

//--- core/sis_pend.v
// bank of sticky pending flags, write-one-to-clear
`timescale 1ns/100ps
module sis_pend #(
  parameter W = 41
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] set,
  input wire [W-1:0] clr,
  output reg [W-1:0] flags
);
  // a set arriving with its own clear still lands
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      flags <= {W{1'b0}};
    else
      flags <= (flags & ~clr) | set;
  end
endmodule // sis_pend

//--- core/sis_tmo.v
// response watchdog: one pulse when a wait outlasts the limit
`timescale 1ns/100ps
module sis_tmo #(
  parameter TW = 16
) (
  input wire clk,
  input wire rst_n,
  input wire busy,
  input wire [TW-1:0] limit,
  output reg expired
);
  reg [TW-1:0] cnt;
  reg fired;
  // counts busy cycles; fires once per wait, re-armed when busy drops
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= {TW{1'b0}};
      fired <= 1'b0;
      expired <= 1'b0;
    end else if (!busy) begin
      cnt <= {TW{1'b0}};
      fired <= 1'b0;
      expired <= 1'b0;
    end else if (!fired && cnt == limit) begin
      fired <= 1'b1;
      expired <= 1'b1;
    end else begin
      expired <= 1'b0;
      if (!fired)
        cnt <= cnt + 1'b1;
    end
  end
endmodule // sis_tmo

//--- core/sis_top.v
// system interrupt source collector with AXI4-Lite register access
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "sis_consts.vh"
module sis_top #(
  parameter PENDW = 41,
  parameter TW = 16,
  parameter [31:0] INHIB_LO = `SIS_INHIB_LO,
  parameter [31:0] INHIB_HI = `SIS_INHIB_HI
) (
  input wire clk,
  input wire rst_n,
  input wire [11:0] s_awaddr,
  input wire s_awvalid,
  output reg s_awready,
  input wire [31:0] s_wdata,
  input wire [3:0] s_wstrb,
  input wire s_wvalid,
  output reg s_wready,
  output reg [1:0] s_bresp,
  output reg s_bvalid,
  input wire s_bready,
  input wire [11:0] s_araddr,
  input wire s_arvalid,
  output reg s_arready,
  output reg [31:0] s_rdata,
  output reg [1:0] s_rresp,
  output reg s_rvalid,
  input wire s_rready,
  input wire optical_drive_irq,
  input wire sound_chip_irq,
  input wire modem_irq,
  input wire external_device_irq,
  output reg [3:0] level_irq,
  input wire [2:0] dma_addr_set,
  input wire [95:0] dma_addr,
  input wire [2:0] dma_start,
  input wire [2:0] dma_acc,
  input wire [95:0] dma_acc_addr,
  input wire [3:0] exp_start,
  input wire [3:0] exp_done,
  input wire [3:0] exp_wait,
  input wire cpu_wait,
  input wire cpu_acc,
  input wire [31:0] cpu_addr,
  input wire channel2_dma_done,
  input wire sort_dma_done,
  input wire sort_dma_cmd_error,
  input wire sort_global_load,
  input wire render_video_done,
  input wire render_hsr_done,
  input wire render_shade_done,
  input wire [9:0] raster_line,
  input wire line_start,
  input wire param_cache_overflow,
  input wire strip_hazard,
  input wire mb_stored,
  input wire [4:0] list_eol,
  input wire store_idle,
  input wire param_wr,
  input wire [31:0] param_addr,
  input wire obj_wr,
  input wire [31:0] obj_addr,
  input wire ta_param_valid,
  input wire ta_param_vertex,
  input wire ta_param_eos,
  input wire in_fifo_wr,
  input wire in_fifo_full,
  output wire [PENDW-1:0] pend_flags
);
  reg [31:0] cfg [0:`SIS_CFG_NUM-1];
  reg [31:0] held_addr [0:2];
  reg [3:0] lvl_s1;
  reg [11:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg aw_got;
  reg w_got;
  reg [2:0] sys_bad;
  reg [2:0] sys_ovr;
  reg [3:0] exp_bad;
  reg vbs;
  reg vbe;
  reg hbs;
  reg [9:0] hcnt;
  reg [15:0] mbcnt;
  reg yuv_done;
  reg [4:0] eol_seen;
  reg [4:0] list_done;
  reg in_strip;
  reg [PENDW-1:0] pend_set;
  reg [PENDW-1:0] pend_clr;
  reg [31:0] rd_val;
  reg rd_ok;
  wire [4:0] tmo_hit;
  wire [4:0] tmo_busy;
  wire [63:0] pend64;
  wire wr_fire;
  wire wr_cfg;
  wire [3:0] wr_idx;
  wire [31:0] wr_val;
  wire [31:0] wmask;
  integer k;

  // a is inside [lo, hi]
  function in_rng;
    input [31:0] a;
    input [31:0] lo;
    input [31:0] hi;
    begin
      in_rng = (a >= lo) && (a <= hi);
    end
  endfunction

  // legal DMA address for one kind; the window works on 64 KB granules
  function legal;
    input [1:0] kind;
    input [31:0] a;
    input [31:0] prot;
    reg win;
    reg wave;
    reg tex;
    reg sys;
    begin
      win = (a[31:16] >= prot[`SIS_WIN_LO]) && (a[31:16] <= prot[`SIS_WIN_HI]);
      wave = in_rng(a, `SIS_WAVE_LO, `SIS_WAVE_HI);
      tex = in_rng(a, `SIS_TEX_LO, `SIS_TEX_HI);
      sys = in_rng(a, `SIS_SYS_LO, `SIS_SYS_HI);
      case (kind)
        `SIS_K_GFX: legal = tex | sys | win;
        `SIS_K_PER: legal = sys | win;
        `SIS_K_BOOT: begin
          legal = wave | tex | sys | win |
                  in_rng(a, `SIS_EXT_LO, `SIS_EXT_HI);
        end
        default: legal = wave | tex | sys | win;
      endcase
    end
  endfunction

  // is this byte address one of the configuration words
  function is_cfg;
    input [11:0] a;
    begin
      is_cfg = (a[11:6] == `SIS_CFG_PAGE) && (a[5:2] < `SIS_CFG_NUM);
    end
  endfunction

  // byte-lane merge of a write into an old word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] d;
    input [3:0] s;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (s[b])
          merge[b*8 +: 8] = d[b*8 +: 8];
      end
    end
  endfunction

  assign wr_fire = aw_got && w_got && !s_bvalid;
  assign wr_cfg = wr_fire && is_cfg(aw_addr);
  assign wr_idx = aw_addr[5:2];
  assign wr_val = merge(cfg[wr_idx], w_data, w_strb);
  assign wmask = merge(32'h0000_0000, w_data, w_strb);
  assign tmo_busy = {cpu_wait, exp_wait};
  assign pend64 = {{(64-PENDW){1'b0}}, pend_flags};

  // write channel: address and data taken in either order
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= `SIS_RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      s_awready <= s_awvalid && !aw_got && !s_awready && !s_bvalid;
      s_wready <= s_wvalid && !w_got && !s_wready && !s_bvalid;
      if (s_awready && s_awvalid) begin
        aw_got <= 1'b1;
        aw_addr <= s_awaddr;
      end
      if (s_wready && s_wvalid) begin
        w_got <= 1'b1;
        w_data <= s_wdata;
        w_strb <= s_wstrb;
      end
      if (wr_fire) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_bvalid <= 1'b1;
        // level word is read-only: writes land nowhere but answer okay
        if (is_cfg(aw_addr) || aw_addr == `SIS_PEND0_OFS ||
            aw_addr == `SIS_PEND1_OFS || aw_addr == `SIS_LEVEL_OFS)
          s_bresp <= `SIS_RESP_OKAY;
        else
          s_bresp <= `SIS_RESP_SLVERR;
      end else if (s_bvalid && s_bready)
        s_bvalid <= 1'b0;
    end
  end

  // configuration words
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (k = 0; k < `SIS_CFG_NUM; k = k + 1)
        cfg[k] <= `SIS_CFG_RST;
      cfg[`SIS_CFG_TMO] <= `SIS_TMO_RST;
    end else if (wr_cfg)
      cfg[wr_idx] <= wr_val;
  end

  // read mux
  always @* begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_araddr == `SIS_PEND0_OFS)
      rd_val = pend64[31:0];
    else if (s_araddr == `SIS_PEND1_OFS)
      rd_val = pend64[63:32];
    else if (s_araddr == `SIS_LEVEL_OFS)
      rd_val = {28'h0000000, level_irq};
    else if (is_cfg(s_araddr))
      rd_val = cfg[s_araddr[5:2]];
    else
      rd_ok = 1'b0;
  end

  // read channel: one word per request, answer registered
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= `SIS_RESP_OKAY;
    end else begin
      s_arready <= s_arvalid && !s_arready && !s_rvalid;
      if (s_arready && s_arvalid) begin
        s_rvalid <= 1'b1;
        s_rdata <= rd_val;
        s_rresp <= rd_ok ? `SIS_RESP_OKAY : `SIS_RESP_SLVERR;
      end else if (s_rvalid && s_rready)
        s_rvalid <= 1'b0;
    end
  end

  // external levels: two flops, never latched
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_s1 <= 4'h0;
      level_irq <= 4'h0;
    end else begin
      lvl_s1 <= {external_device_irq, modem_irq, sound_chip_irq,
                 optical_drive_irq};
      level_irq <= lvl_s1;
    end
  end

  // graphics, peripheral and boot DMA checks; start uses the held address
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_bad <= 3'h0;
      sys_ovr <= 3'h0;
      for (k = 0; k < 3; k = k + 1)
        held_addr[k] <= 32'h0000_0000;
    end else begin
      for (k = 0; k < 3; k = k + 1) begin
        if (dma_addr_set[k])
          held_addr[k] <= dma_addr[k*32 +: 32];
        sys_bad[k] <= (dma_addr_set[k] &&
          !legal(k[1:0], dma_addr[k*32 +: 32], cfg[k])) ||
          (dma_start[k] && !legal(k[1:0], held_addr[k], cfg[k]));
        sys_ovr[k] <= dma_acc[k] &&
          !legal(k[1:0], dma_acc_addr[k*32 +: 32], cfg[k]);
      end
    end
  end

  // expansion start addresses: checked when written and at each start
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      exp_bad <= 4'h0;
    else begin
      for (k = 0; k < 4; k = k + 1) begin
        exp_bad[k] <= (wr_cfg && wr_idx == `SIS_CFG_EXP_SA0 + k &&
          !legal(`SIS_K_EXP, wr_val, cfg[`SIS_CFG_EXP_PROT])) ||
          (exp_start[k] && !legal(`SIS_K_EXP, cfg[`SIS_CFG_EXP_SA0 + k],
          cfg[`SIS_CFG_EXP_PROT]));
      end
    end
  end

  // raster events, sampled on the first cycle of each line
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vbs <= 1'b0;
      vbe <= 1'b0;
      hbs <= 1'b0;
      hcnt <= 10'h000;
    end else if (!line_start) begin
      vbs <= 1'b0;
      vbe <= 1'b0;
      hbs <= 1'b0;
    end else begin
      vbs <= raster_line == cfg[`SIS_CFG_VBLANK][`SIS_LINE_A];
      vbe <= raster_line == cfg[`SIS_CFG_VBLANK][`SIS_LINE_B];
      case (cfg[`SIS_CFG_HBLANK][`SIS_HMODE])
        `SIS_HM_LINE: begin
          hbs <= raster_line == cfg[`SIS_CFG_HBLANK][`SIS_LINE_A];
        end
        `SIS_HM_EVERY_N: begin
          // an interval of 0 or 1 degenerates to every line
          if (hcnt + 10'h001 >= cfg[`SIS_CFG_HBLANK][`SIS_LINE_B]) begin
            hbs <= 1'b1;
            hcnt <= 10'h000;
          end else begin
            hbs <= 1'b0;
            hcnt <= hcnt + 10'h001;
          end
        end
        default: hbs <= 1'b1;
      endcase
    end
  end

  // macroblock count; rewriting the control word restarts the count
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mbcnt <= 16'h0000;
      yuv_done <= 1'b0;
    end else if (wr_cfg && wr_idx == `SIS_CFG_YUV) begin
      mbcnt <= 16'h0000;
      yuv_done <= 1'b0;
    end else if (mb_stored &&
                 mbcnt + 16'h0001 >= cfg[`SIS_CFG_YUV][`SIS_MB_CNT]) begin
      mbcnt <= 16'h0000;
      yuv_done <= 1'b1;
    end else begin
      yuv_done <= 1'b0;
      if (mb_stored)
        mbcnt <= mbcnt + 16'h0001;
    end
  end

  // list ends wait for the store path to drain; strip tracking
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eol_seen <= 5'h00;
      list_done <= 5'h00;
      in_strip <= 1'b0;
    end else begin
      list_done <= eol_seen & {5{store_idle}};
      eol_seen <= (eol_seen | list_eol) & ~(eol_seen & {5{store_idle}});
      if (ta_param_valid)
        in_strip <= ta_param_vertex && !ta_param_eos;
    end
  end

  // collect every event into the pending bank
  always @* begin
    pend_set = {PENDW{1'b0}};
    pend_set[`SIS_B_EXP_DONE +: 4] = exp_done;
    pend_set[`SIS_B_EXP_BAD +: 4] = exp_bad;
    pend_set[`SIS_B_EXP_TMO +: 4] = tmo_hit[3:0];
    pend_set[`SIS_B_CPU_TMO] = tmo_hit[4];
    pend_set[`SIS_B_CH2_DONE] = channel2_dma_done;
    pend_set[`SIS_B_SORT_DONE] = sort_dma_done;
    pend_set[`SIS_B_SORT_ERR] = sort_dma_cmd_error &&
      sort_global_load;
    pend_set[`SIS_B_INHIB] = cpu_acc &&
      in_rng(cpu_addr, INHIB_LO, INHIB_HI);
    pend_set[`SIS_B_RVIDEO] = render_video_done;
    pend_set[`SIS_B_RHSR] = render_hsr_done;
    pend_set[`SIS_B_RSHADE] = render_shade_done;
    pend_set[`SIS_B_VBS] = vbs;
    pend_set[`SIS_B_VBE] = vbe;
    pend_set[`SIS_B_HBS] = hbs;
    pend_set[`SIS_B_CACHE] = param_cache_overflow;
    pend_set[`SIS_B_HAZARD] = strip_hazard;
    pend_set[`SIS_B_YUV] = yuv_done;
    pend_set[`SIS_B_LISTS +: 5] = list_done;
    pend_set[`SIS_B_PLIM] = param_wr &&
      param_addr > cfg[`SIS_CFG_PLIMIT];
    pend_set[`SIS_B_OLIM] = obj_wr &&
      obj_addr > cfg[`SIS_CFG_OLIMIT];
    pend_set[`SIS_B_ILLPAR] = ta_param_valid && !ta_param_vertex &&
      in_strip;
    pend_set[`SIS_B_FIFO] = in_fifo_wr && in_fifo_full;
    pend_set[`SIS_B_SYS_BAD +: 3] = sys_bad;
    pend_set[`SIS_B_SYS_OVR +: 3] = sys_ovr;
  end

  // acknowledge: ones written to a pending word clear those flags
  always @* begin
    pend_clr = {PENDW{1'b0}};
    if (wr_fire && aw_addr == `SIS_PEND0_OFS)
      pend_clr[31:0] = wmask;
    else if (wr_fire && aw_addr == `SIS_PEND1_OFS)
      pend_clr[PENDW-1:32] = wmask[PENDW-33:0];
  end

  sis_pend #(.W(PENDW)) u_pend (
    .clk(clk),
    .rst_n(rst_n),
    .set(pend_set),
    .clr(pend_clr),
    .flags(pend_flags)
  );

  // one watchdog per expansion channel plus the processor path
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_tmo
      sis_tmo #(.TW(TW)) u_tmo (
        .clk(clk),
        .rst_n(rst_n),
        .busy(tmo_busy[gi]),
        .limit(cfg[`SIS_CFG_TMO][TW-1:0]),
        .expired(tmo_hit[gi])
      );
    end
  endgenerate
endmodule // sis_top

//--- verification/sis_checker_assertions.sv
// port-level checks for the interrupt source collector
`timescale 1ns/100ps
module sis_checker #(
  parameter PENDW = 41
) (
  input wire clk,
  input wire rst_n,
  input wire s_bvalid,
  input wire optical_drive_irq,
  input wire [3:0] level_irq,
  input wire [3:0] exp_done,
  input wire channel2_dma_done,
  input wire sort_dma_cmd_error,
  input wire sort_global_load,
  input wire render_hsr_done,
  input wire render_shade_done,
  input wire strip_hazard,
  input wire in_fifo_wr,
  input wire in_fifo_full,
  input wire [PENDW-1:0] pend_flags
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_done;
    exp_done[3] |=> pend_flags[3];
  endproperty
  a_done: assert property (p_done) else $error("done flag lost");
  property p_ch2;
    channel2_dma_done |=> pend_flags[13];
  endproperty
  a_ch2: assert property (p_ch2) else $error("ch2 flag lost");
  property p_sort;
    sort_dma_cmd_error && sort_global_load |=> pend_flags[15];
  endproperty
  a_sort: assert property (p_sort) else $error("sort flag lost");
  property p_tile;
    render_hsr_done && !render_shade_done
      |=> pend_flags[18] ##0 !$rose(pend_flags[19]);
  endproperty
  a_tile: assert property (p_tile) else $error("tiles mixed");
  property p_haz;
    strip_hazard |=> pend_flags[24];
  endproperty
  a_haz: assert property (p_haz) else $error("hazard flag lost");
  property p_fifo;
    in_fifo_wr && in_fifo_full |=> pend_flags[34];
  endproperty
  a_fifo: assert property (p_fifo) else $error("overflow lost");
  // two-flop sync: a level held three edges must show through
  property p_lvl;
    $stable(optical_drive_irq) [*3] |-> level_irq[0] == optical_drive_irq;
  endproperty
  a_lvl: assert property (p_lvl) else $error("level not passed");
  // a flag may only drop while a write response is being given
  property p_sticky;
    |($past(pend_flags) & ~pend_flags) |-> s_bvalid;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");
endmodule // sis_checker
bind sis_top sis_checker #(.PENDW(PENDW)) u_sis_checker (
  .clk(clk), .rst_n(rst_n), .s_bvalid(s_bvalid),
  .optical_drive_irq(optical_drive_irq), .level_irq(level_irq),
  .exp_done(exp_done), .channel2_dma_done(channel2_dma_done),
  .sort_dma_cmd_error(sort_dma_cmd_error),
  .sort_global_load(sort_global_load), .render_hsr_done(render_hsr_done),
  .render_shade_done(render_shade_done), .strip_hazard(strip_hazard),
  .in_fifo_wr(in_fifo_wr), .in_fifo_full(in_fifo_full),
  .pend_flags(pend_flags)
);

//--- verification/sis_host_model.sv
// host interrupt input: one request from pending flags and levels
`timescale 1ns/100ps
module sis_host_model (
  input wire clk,
  input wire rst_n,
  input wire [40:0] pend_flags,
  input wire [3:0] level_irq,
  output logic irq_req
);
  // request stays up while any flag is pending or any level input is high
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req <= 1'h0;
    end else begin
      irq_req <= (|pend_flags) || (|level_irq);
    end
  end
endmodule // sis_host_model

//--- verification/sis_testbench.sv
// self-checking bench for the interrupt source collector
`timescale 1ns/100ps
module testbench;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [11:0] s_awaddr = 12'h000, s_araddr = 12'h000;
  logic [31:0] s_wdata = 32'h0, a32 = 32'h0, rng = 32'h7FE7CFA7;
  logic [3:0] s_wstrb = 4'hF, irq = 4'h0;
  logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0;
  logic s_arvalid = 1'h0, s_rready = 1'h0;
  logic [47:0] ev = 48'h0;
  logic [9:0] line = 10'h000;
  wire s_awready, s_wready, s_bvalid, s_arready, s_rvalid, host_irq;
  wire [1:0] s_bresp, s_rresp;
  wire [31:0] s_rdata;
  wire [3:0] level_irq;
  wire [40:0] pend_flags;
  logic [33:0] q_r[$];
  logic [1:0] q_b[$];
  integer errors = 0, checked = 0;
  int pb[11] = '{0, 1, 2, 3, 13, 14, 17, 18, 19, 23, 24};
  int kd[10] = '{0, 0, 0, 0, 0, 1, 1, 2, 2, 2};
  // cases 2, 4, 6 and 9 fall outside every legal window of their kind
  logic [9:0] bd = 10'h254;
  logic [31:0] at[10] = '{32'h04000000, 32'h05FFFFE0, 32'h06000000,
    32'h20000040, 32'h0BFFFFE0, 32'h0FFFFFE0, 32'h04000000,
    32'h14000000, 32'h00800000, 32'h18000000};
  always #5 clk = ~clk;
  // a small inhibited region so that the access check can be tripped
  sis_top #(
    .INHIB_LO(32'h00000200),
    .INHIB_HI(32'h000002FF)
  ) u_sis_top (
    .clk(clk), .rst_n(rst_n), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .optical_drive_irq(irq[0]), .sound_chip_irq(irq[1]),
    .modem_irq(irq[2]), .external_device_irq(irq[3]), .level_irq(level_irq),
    .dma_addr_set(ev[19:17]), .dma_addr({3{a32}}), .dma_start(ev[22:20]),
    .dma_acc(ev[25:23]), .dma_acc_addr({3{a32}}), .exp_start(ev[16:13]),
    .exp_done(ev[3:0]), .exp_wait(ev[35:32]), .cpu_wait(ev[36]),
    .cpu_acc(ev[26]), .cpu_addr(a32), .channel2_dma_done(ev[4]),
    .sort_dma_done(ev[5]), .sort_dma_cmd_error(ev[12]),
    .sort_global_load(ev[11]), .render_video_done(ev[6]),
    .render_hsr_done(ev[7]), .render_shade_done(ev[8]),
    .raster_line(line), .line_start(ev[27]), .param_cache_overflow(ev[9]),
    .strip_hazard(ev[10]), .mb_stored(ev[28]), .list_eol(ev[41:37]),
    .store_idle(ev[42]), .param_wr(ev[29]), .param_addr(a32),
    .obj_wr(ev[30]), .obj_addr(a32), .ta_param_valid(ev[43]),
    .ta_param_vertex(ev[44]), .ta_param_eos(ev[45]), .in_fifo_wr(ev[31]),
    .in_fifo_full(ev[46]), .pend_flags(pend_flags)
  );
  sis_host_model u_sis_host_model (
    .clk(clk), .rst_n(rst_n), .pend_flags(pend_flags),
    .level_irq(level_irq), .irq_req(host_irq)
  );
  task automatic check(input string what, input [33:0] seen,
      input [33:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  function automatic [31:0] xs(input [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // write: address and data offered together, each dropped once taken
  task automatic axi_wr(input [11:0] a, input [31:0] d, input [1:0] r);
    @(posedge clk);
    q_b.push_back(r);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    s_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_awready) s_awvalid <= 1'h0;
      if (s_wready) s_wvalid <= 1'h0;
    end while (!(s_bvalid && s_bready));
    s_bready <= 1'h0;
  endtask
  task automatic axi_rd(input [11:0] a, input [31:0] d, input [1:0] r);
    @(posedge clk);
    q_r.push_back({r, d});
    s_araddr <= a;
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_arready) s_arvalid <= 1'h0;
    end while (!(s_rvalid && s_rready));
    s_rready <= 1'h0;
  endtask
  // read a pending bank, then ack everything in it
  task automatic see(input [11:0] a, input [31:0] e);
    axi_rd(a, e, 2'h0);
    axi_wr(a, 32'hFFFFFFFF, 2'h0);
  endtask
  // extra edge after the pulse keeps qualifiers steady behind it
  task automatic pulse(input integer i);
    @(posedge clk);
    ev[i] <= 1'h1;
    @(posedge clk);
    ev[i] <= 1'h0;
    @(posedge clk);
  endtask
  // response monitor takes the oldest expectation per answer
  always @(posedge clk) begin
    if (s_bvalid && s_bready)
      check("bresp", s_bresp, q_b.pop_front());
    if (s_rvalid && s_rready)
      check("rdata", {s_rresp, s_rdata}, q_r.pop_front());
  end
  // scenarios need under a thousand cycles; the limit leaves a wide margin
  initial begin
    #200000;
    errors++;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    axi_rd(12'h064, 32'h000000FF, 2'h0);
    axi_wr(12'h0FC, 32'h1, 2'h2);
    axi_rd(12'h0FC, 32'h0, 2'h2);
    for (int i = 0; i < 11; i++) begin
      pulse(i);
      // host request is one flop behind the pending bank
      @(posedge clk);
      check("host_irq", host_irq, 34'h1);
      see(12'h000, 32'h1 << pb[i]);
    end
    pulse(12);
    see(12'h000, 32'h0);
    ev[11] <= 1'h1;
    pulse(12);
    see(12'h000, 32'h8000);
    axi_wr(12'h068, 32'h20000000, 2'h0);
    see(12'h000, 32'h10);
    pulse(13);
    see(12'h000, 32'h10);
    axi_wr(12'h068, 32'h00800000, 2'h0);
    pulse(13);
    see(12'h000, 32'h0);
    axi_wr(12'h040, 32'h20002000, 2'h0);
    for (int k = 0; k < 10; k++) begin
      a32 <= at[k];
      pulse(17 + kd[k]);
      pulse(20 + kd[k]);
      pulse(23 + kd[k]);
      see(12'h004, bd[k] ? 32'h48 << kd[k] : 32'h0);
    end
    axi_wr(12'h064, 32'h4, 2'h0);
    for (int n = 3; n < 10; n += 4) begin
      ev[36:32] <= 5'h1F;
      repeat (n) @(posedge clk);
      ev[36:32] <= 5'h00;
      see(12'h000, n > 4 ? 32'h1F00 : 32'h0);
    end
    for (int n = 0; n < 4; n++) begin
      rng = xs(rng);
      irq <= rng[3:0];
      repeat (3) @(posedge clk);
      axi_rd(12'h008, {28'h0, rng[3:0]}, 2'h0);
    end
    axi_wr(12'h008, 32'h0, 2'h0);
    pulse(31);
    see(12'h004, 32'h0);
    ev[46] <= 1'h1;
    pulse(31);
    see(12'h004, 32'h4);
    axi_wr(12'h058, 32'h100, 2'h0);
    axi_wr(12'h05C, 32'h100, 2'h0);
    a32 <= 32'h100;
    pulse(29);
    pulse(30);
    see(12'h000, 32'h0);
    a32 <= 32'h101;
    pulse(29);
    pulse(30);
    see(12'h000, 32'h80000000);
    see(12'h004, 32'h1);
    ev[42] <= 1'h1;
    for (int k = 0; k < 5; k++) begin
      pulse(37 + k);
      see(12'h000, 32'h04000000 << k);
    end
    ev[44] <= 1'h1;
    pulse(43);
    ev[44] <= 1'h0;
    pulse(43);
    see(12'h004, 32'h2);
    axi_wr(12'h050, 32'h0014000A, 2'h0);
    line <= 10'h00A;
    pulse(27);
    line <= 10'h014;
    pulse(27);
    see(12'h000, 32'h00300000);
    // leave the vblank lines so only the hblank event can fire
    line <= 10'h003;
    axi_wr(12'h054, 32'h2000, 2'h0);
    pulse(27);
    see(12'h000, 32'h00400000);
    axi_wr(12'h054, 32'h00031000, 2'h0);
    pulse(27);
    pulse(27);
    see(12'h000, 32'h0);
    pulse(27);
    see(12'h000, 32'h00400000);
    axi_wr(12'h054, 32'h3, 2'h0);
    pulse(27);
    see(12'h000, 32'h00400000);
    axi_wr(12'h060, 32'h2, 2'h0);
    pulse(28);
    pulse(26);
    see(12'h000, 32'h0);
    pulse(28);
    see(12'h000, 32'h02000000);
    a32 <= 32'h200;
    pulse(26);
    see(12'h000, 32'h00010000);
    tally_and_finish;
  end
endmodule // testbench
